/* hdl/asp_defs.vh */
// constants for the async serial port with break
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
// register byte offsets
`define ASP_CTRL_OFS 12'h000
`define ASP_BAUD_OFS 12'h004
`define ASP_TXDATA_OFS 12'h008
`define ASP_RXDATA_OFS 12'h00c
`define ASP_STAT_OFS 12'h010
`define ASP_MASK_OFS 12'h014
`define ASP_BRKTH_OFS 12'h018
// ctrl fields
`define ASP_C_FLOW 0
`define ASP_C_PAR_LO 1
`define ASP_C_PAR_HI 2
`define ASP_C_STOP2 3
`define ASP_C_BRKRST 4
`define ASP_C_BRKTX 5
`define ASP_C_RXEN 6
// parity encodings
`define ASP_PAR_NONE 2'h0
`define ASP_PAR_ODD 2'h1
`define ASP_PAR_EVEN 2'h2
// status bits
`define ASP_S_RXDONE 0
`define ASP_S_TXDONE 1
`define ASP_S_PERR 2
`define ASP_S_FERR 3
`define ASP_S_BRK 4
`define ASP_S_OVR 5
`define ASP_NSTAT 6
// reset values
`define ASP_CTRL_RST 7'h40
// 20 MHz / 115200 rounded down; bit time is this value plus one pclk cycles
`define ASP_BAUD_RST 16'h00ad
// break threshold in pclk cycles (default 10 ms at 20 MHz)
`define ASP_BRKTH_RST 32'h00030d40
`endif

/* hdl/asp_uart.v */
// async serial port with break detect/reset and break transmit, apb slave
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// RULE_01: receive on rx input, send on tx
// RULE_02: optional flow control, rts and cts low
// RULE_03: baud 1200..3M, parity none/odd/even, 1/2 stop
// RULE_04: rx low beyond threshold issues system reset
// RULE_05: optional break driven on tx output
// RULE_06: break reset and break send default off
// RULE_07: break at startup holds low power, no init
// RULE_08: idle high, start low, lsb first, cts gates
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "asp_defs.vh"
module asp_uart #(
    parameter BRK_TH_RST = `ASP_BRKTH_RST
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire uart_rx,
    output reg uart_tx,
    input wire uart_cts_n,
    output reg uart_rts_n,
    output reg irq,
    output reg sys_reset_req,
    output reg boot_hold
);
// ****************************************************************
// registers
// ****************************************************************
reg [6:0] ctrl_r;
reg [15:0] baud_r;
reg [31:0] brkth_r;
reg [`ASP_NSTAT-1:0] stat_r;
reg [`ASP_NSTAT-1:0] mask_r;
reg [7:0] rxdata_r;
reg rxfull_r;
reg [7:0] txdata_r;
reg txpend_r;
wire [`ASP_NSTAT-1:0] ev;
wire acc = psel & penable & ~pready;
// writes land at the completing edge, where the master sees pready
wire wr = psel & penable & pready & pwrite;
wire rd = acc & ~pwrite;
function known;
    input [11:0] a;
    begin
        known = (a == `ASP_CTRL_OFS) || (a == `ASP_BAUD_OFS) ||
            (a == `ASP_TXDATA_OFS) || (a == `ASP_RXDATA_OFS) ||
            (a == `ASP_STAT_OFS) || (a == `ASP_MASK_OFS) ||
            (a == `ASP_BRKTH_OFS);
    end
endfunction
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_r <= `ASP_CTRL_RST; // RULE_06
        baud_r <= `ASP_BAUD_RST;
        brkth_r <= BRK_TH_RST;
        mask_r <= {`ASP_NSTAT{1'b0}};
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= acc;
        pslverr <= acc & ~known(paddr);
        if (wr) begin
            case (paddr)
            `ASP_CTRL_OFS: ctrl_r <= pwdata[6:0]; // RULE_03
            `ASP_BAUD_OFS: baud_r <= pwdata[15:0];
            `ASP_MASK_OFS: mask_r <= pwdata[`ASP_NSTAT-1:0];
            `ASP_BRKTH_OFS: brkth_r <= pwdata;
            default: ;
            endcase
        end
        if (rd) begin
            case (paddr)
            `ASP_CTRL_OFS: prdata <= {25'h0, ctrl_r};
            `ASP_BAUD_OFS: prdata <= {16'h0, baud_r};
            `ASP_TXDATA_OFS: prdata <= {23'h0, txpend_r, txdata_r};
            `ASP_RXDATA_OFS: prdata <= {23'h0, rxfull_r, rxdata_r};
            `ASP_STAT_OFS: prdata <= {26'h0, stat_r};
            `ASP_MASK_OFS: prdata <= {26'h0, mask_r};
            `ASP_BRKTH_OFS: prdata <= brkth_r;
            default: prdata <= 32'h00000000;
            endcase
        end
    end
end
// ****************************************************************
// interrupts: set wins over write-one-to-clear
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stat_r <= {`ASP_NSTAT{1'b0}};
        irq <= 1'b0;
    end else begin
        if (wr && paddr == `ASP_STAT_OFS)
            stat_r <= (stat_r & ~pwdata[`ASP_NSTAT-1:0]) | ev;
        else
            stat_r <= stat_r | ev;
        irq <= |(stat_r & mask_r);
    end
end
// ****************************************************************
// transmitter
// ****************************************************************
localparam TX_IDLE = 2'h0;
localparam TX_SHIFT = 2'h1;
localparam TX_BRK = 2'h2;
reg [1:0] tx_st_r;
reg [15:0] tx_cnt_r;
reg [3:0] tx_bit_r;
reg [10:0] tx_sh_r;
reg [3:0] tx_len_r;
reg tx_done_p;
wire par_odd = ctrl_r[`ASP_C_PAR_HI:`ASP_C_PAR_LO] == `ASP_PAR_ODD;
wire par_on = ctrl_r[`ASP_C_PAR_HI:`ASP_C_PAR_LO] != `ASP_PAR_NONE;
wire tx_tick = (tx_cnt_r == 16'h0000);
// cts gates only frame start; a frame in flight always completes
wire cts_ok = ~ctrl_r[`ASP_C_FLOW] | ~uart_cts_n; // RULE_02 RULE_08
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_st_r <= TX_IDLE;
        tx_cnt_r <= 16'h0000;
        tx_bit_r <= 4'h0;
        tx_sh_r <= 11'h7ff;
        tx_len_r <= 4'h0;
        uart_tx <= 1'b1;
        txpend_r <= 1'b0;
        txdata_r <= 8'h00;
        tx_done_p <= 1'b0;
    end else begin
        tx_done_p <= 1'b0;
        if (wr && paddr == `ASP_TXDATA_OFS && !txpend_r) begin
            txdata_r <= pwdata[7:0];
            txpend_r <= 1'b1;
        end
        case (tx_st_r)
        TX_IDLE: begin
            uart_tx <= 1'b1; // RULE_08
            if (ctrl_r[`ASP_C_BRKTX]) begin
                tx_st_r <= TX_BRK; // RULE_05 RULE_06
            end else if (txpend_r && cts_ok) begin
                // parity bit, then stop bits high; lsb first
                tx_sh_r <= {2'h3, par_on ? (^txdata_r ^ par_odd) : 1'b1,
                    txdata_r}; // RULE_08
                tx_len_r <= par_on ? (ctrl_r[`ASP_C_STOP2] ? 4'hb : 4'ha)
                    : (ctrl_r[`ASP_C_STOP2] ? 4'ha : 4'h9);
                tx_bit_r <= 4'h0;
                tx_cnt_r <= baud_r;
                uart_tx <= 1'b0;
                txpend_r <= 1'b0;
                tx_st_r <= TX_SHIFT;
            end
        end
        TX_SHIFT: begin
            if (tx_tick) begin
                tx_cnt_r <= baud_r;
                if (tx_bit_r == tx_len_r) begin
                    uart_tx <= 1'b1;
                    tx_done_p <= 1'b1;
                    tx_st_r <= TX_IDLE;
                end else begin
                    uart_tx <= tx_sh_r[0]; // RULE_01
                    tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                    tx_bit_r <= tx_bit_r + 4'h1;
                end
            end else begin
                tx_cnt_r <= tx_cnt_r - 16'h0001;
            end
        end
        TX_BRK: begin
            // held low until software drops the enable
            uart_tx <= 1'b0; // RULE_05
            if (!ctrl_r[`ASP_C_BRKTX])
                tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
        endcase
    end
end
// ****************************************************************
// receiver and break detector
// ****************************************************************
localparam RX_IDLE = 2'h0;
localparam RX_SHIFT = 2'h1;
reg [1:0] rx_st_r;
reg [15:0] rx_cnt_r;
reg [3:0] rx_bit_r;
reg [10:0] rx_sh_r;
reg [3:0] rx_len_r;
reg rx_done_p;
reg perr_p;
reg ferr_p;
reg ovr_p;
reg [31:0] low_cnt_r;
reg brk_r;
reg boot_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_st_r <= RX_IDLE;
        rx_cnt_r <= 16'h0000;
        rx_bit_r <= 4'h0;
        rx_sh_r <= 11'h000;
        rx_len_r <= 4'h0;
        rxdata_r <= 8'h00;
        rxfull_r <= 1'b0;
        rx_done_p <= 1'b0;
        perr_p <= 1'b0;
        ferr_p <= 1'b0;
        ovr_p <= 1'b0;
        uart_rts_n <= 1'b1;
    end else begin
        rx_done_p <= 1'b0;
        perr_p <= 1'b0;
        ferr_p <= 1'b0;
        ovr_p <= 1'b0;
        if (rd && paddr == `ASP_RXDATA_OFS)
            rxfull_r <= 1'b0;
        // rts low while room for a byte, when flow control is on
        uart_rts_n <= ctrl_r[`ASP_C_FLOW] ? rxfull_r : 1'b0; // RULE_02
        case (rx_st_r)
        RX_IDLE: begin
            if (!uart_rx && ctrl_r[`ASP_C_RXEN] && !boot_r) begin
                rx_cnt_r <= {1'b0, baud_r[15:1]}; // sample mid bit
                rx_bit_r <= 4'h0;
                rx_len_r <= par_on ? 4'ha : 4'h9;
                rx_st_r <= RX_SHIFT;
            end
        end
        RX_SHIFT: begin
            if (rx_cnt_r == 16'h0000) begin
                rx_cnt_r <= baud_r;
                rx_sh_r <= {uart_rx, rx_sh_r[10:1]}; // RULE_01 RULE_08
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && uart_rx) begin
                    rx_st_r <= RX_IDLE; // false start glitch
                end else if (rx_bit_r == rx_len_r) begin
                    rx_st_r <= RX_IDLE;
                    rx_done_p <= 1'b1;
                    ferr_p <= ~uart_rx;
                    ovr_p <= rxfull_r;
                    rxfull_r <= 1'b1;
                    if (par_on) begin
                        rxdata_r <= rx_sh_r[9:2];
                        perr_p <= ^rx_sh_r[10:2] ^ par_odd; // RULE_03
                    end else begin
                        rxdata_r <= rx_sh_r[10:3];
                    end
                end
            end else begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end
        end
        default: rx_st_r <= RX_IDLE;
        endcase
    end
end
// low counter saturates so a long break stays flagged
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_cnt_r <= 32'h00000000;
        brk_r <= 1'b0;
        sys_reset_req <= 1'b0;
        boot_r <= 1'b1;
        boot_hold <= 1'b0;
    end else begin
        if (uart_rx)
            low_cnt_r <= 32'h00000000;
        else if (low_cnt_r != 32'hffffffff)
            low_cnt_r <= low_cnt_r + 32'h00000001;
        brk_r <= ~uart_rx && (low_cnt_r >= brkth_r); // RULE_04
        sys_reset_req <= brk_r & ctrl_r[`ASP_C_BRKRST] & ~boot_r; // RULE_04
        // startup: stay parked while rx is held low
        if (uart_rx)
            boot_r <= 1'b0; // RULE_07
        boot_hold <= boot_r & ~uart_rx; // RULE_07
    end
end
assign ev = {ovr_p, brk_r & ~boot_r, ferr_p, perr_p, tx_done_p, rx_done_p};
endmodule // asp_uart
`default_nettype wire

/* verif/asp_uart_chk.sv */
// assertion checker bound to the async serial port
`default_nettype none
module asp_uart_chk #(
    parameter BRK_TH_RST = 32'h00030d40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic uart_rx,
    input wire logic irq,
    input wire logic sys_reset_req,
    input wire logic boot_hold
);
    // ****
    // port checks
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_one: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_access_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    a_pready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_rdata: assert property (pready && pslverr && !pwrite |-> !prdata)
        else $error("refused read returned data");
    a_rst_hold: assert property (sys_reset_req |-> !boot_hold)
        else $error("reset during startup hold");
    // detect must follow a long low, lag allowed for the brk_r and sys_reset_req registers
    a_rst_brk: assert property ($rose(sys_reset_req) |->
        !$past(uart_rx, 4) && !$past(uart_rx, 30))
        else $error("reset without break");
    a_rst_drop: assert property (uart_rx [*8] |=> !sys_reset_req)
        else $error("reset kept after break");
    c_irq: cover property ($rose(irq));
    c_rst: cover property ($rose(sys_reset_req));
    c_err: cover property (pready && pslverr);
endmodule // asp_uart_chk
bind asp_uart asp_uart_chk #(.BRK_TH_RST(BRK_TH_RST)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uart_rx(uart_rx), .irq(irq),
    .sys_reset_req(sys_reset_req), .boot_hold(boot_hold));
`default_nettype wire

/* verif/asp_host.sv */
// behavioural serial host facing the port
`default_nettype none
module asp_host (
    input wire logic pclk,
    input wire logic [15:0] bt,
    input wire logic kick,
    input wire logic [7:0] d,
    input wire logic brk,
    input wire logic tx,
    output logic line,
    output logic [7:0] got,
    output logic got_v
);
    // ****
    // send and decode
    // ****
    logic s;
    logic [7:0] g;
    assign line = brk ? 1'b0 : s;
    initial begin
        s = 1'b1;
        forever begin
            @(posedge pclk);
            if (kick) begin
                s <= 1'b0;
                repeat (bt) @(posedge pclk);
                for (int j = 0; j < 8; j++) begin
                    s <= d[j];
                    repeat (bt) @(posedge pclk);
                end
                s <= 1'b1;
            end
        end
    end
    // parity ignored; rearm at the end of the slot after bit 7,
    // since the next start may follow a single stop bit
    initial begin
        got_v = 1'b0;
        got = 8'h00;
        forever begin
            @(negedge tx);
            repeat (bt / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (bt) @(posedge pclk);
                g[i] = tx;
            end
            got <= g;
            got_v <= 1'b1;
            @(posedge pclk) got_v <= 1'b0;
            repeat (bt + bt / 2 - 1) @(posedge pclk);
        end
    end
endmodule // asp_host
`default_nettype wire

/* verif/async_serial_port_with_break_tb.sv */
// self-checking bench for the async serial port
`default_nettype none
`include "asp_defs.vh"
module async_serial_port_with_break_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BT = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic uart_tx, uart_cts_n, uart_rts_n, irq, sys_reset_req, boot_hold;
    logic line, kick, brk, got_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, b;
    logic [7:0] hd, got;
    logic [6:0] modes [4] = '{7'h40, 7'h42, 7'h44, 7'h4c};
    int n_fail, checked, seed;
    asp_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uart_rx(line), .uart_tx(uart_tx), .uart_cts_n(uart_cts_n),
        .uart_rts_n(uart_rts_n), .irq(irq), .sys_reset_req(sys_reset_req),
        .boot_hold(boot_hold));
    asp_host u_host (.pclk(pclk), .bt(16'(BT)), .kick(kick), .d(hd),
        .brk(brk), .tx(uart_tx), .line(line), .got(got), .got_v(got_v));
    always #25 pclk = ~pclk;
    // ****
    // helpers
    // ****
    function automatic logic [31:0] rxword(input logic [7:0] v);
        return {23'h0, 1'b1, v};
    endfunction
    // idle line in the parity slot: even check fails on even data
    function automatic logic [31:0] rxstat(input logic [7:0] v);
        return {29'h0, ~^v, 2'b01};
    endfunction
    task automatic close_out;
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x,
            input logic [31:0] g);
        checked++;
        if (g !== x) begin
            $display("unexpected %s exp %h got %h", n, x, g);
            n_fail++;
        end
    endtask
    // psel drops a cycle between transfers, never reassigned in one step
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk) penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            $display("unexpected pready exp 1 got %b", pready);
            n_fail++;
            close_out;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
            input string n);
        apb(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask
    task automatic wait_got;
        int k;
        for (k = 0; k < 3000 && got_v !== 1'b1; k++) @(posedge pclk);
        if (got_v !== 1'b1) begin
            $display("unexpected got_v exp 1 got %b", got_v);
            n_fail++;
            close_out;
        end
    endtask
    // ****
    // scenarios
    // ****
    initial begin
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        uart_cts_n = 0;
        kick = 0;
        brk = 0;
        hd = 0;
        n_fail = 0;
        checked = 0;
        seed = 32'h2d74;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ASP_CTRL_OFS, 32'h40, "ctrl");
        rd(`ASP_BAUD_OFS, 32'had, "baud");
        rd(`ASP_BRKTH_OFS, `ASP_BRKTH_RST, "brkth");
        rd(`ASP_MASK_OFS, 32'h0, "mask");
        rd(12'hffc, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, e});
        chk("rts_n", 32'h0, {31'h0, uart_rts_n});
        apb(1'b1, `ASP_BAUD_OFS, BT - 1);
        apb(1'b1, `ASP_MASK_OFS, 32'h3f);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `ASP_CTRL_OFS, {25'h0, modes[i]});
            b = $random(seed) & 32'hff;
            apb(1'b1, `ASP_TXDATA_OFS, b);
            wait_got;
            chk("txbyte", b, {24'h0, got});
        end
        repeat (5 * BT) @(posedge pclk);
        chk("irq_tx", 32'h1, {31'h0, irq});
        // flow on so rts shows the full buffer; even parity, no parity bit
        apb(1'b1, `ASP_CTRL_OFS, 32'h4d);
        apb(1'b1, `ASP_STAT_OFS, 32'h3f);
        apb(1'b1, `ASP_MASK_OFS, 32'h0);
        hd <= 8'($random(seed));
        @(posedge pclk) kick <= 1'b1;
        @(posedge pclk) kick <= 1'b0;
        repeat (12 * BT) @(posedge pclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        chk("rts_full", 32'h1, {31'h0, uart_rts_n});
        rd(`ASP_RXDATA_OFS, rxword(hd), "rxdata");
        rd(`ASP_STAT_OFS, rxstat(hd), "stat");
        apb(1'b1, `ASP_MASK_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, `ASP_STAT_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b1, `ASP_CTRL_OFS, 32'h41);
        uart_cts_n <= 1'b1;
        b = $random(seed) & 32'hff;
        apb(1'b1, `ASP_TXDATA_OFS, b);
        repeat (4 * BT) @(posedge pclk);
        chk("tx_held", 32'h1, {31'h0, uart_tx});
        rd(`ASP_TXDATA_OFS, rxword(b[7:0]), "txpend");
        uart_cts_n <= 1'b0;
        wait_got;
        chk("tx_flow", b, {24'h0, got});
        apb(1'b1, `ASP_BRKTH_OFS, 32'd50);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `ASP_CTRL_OFS, m ? 32'h50 : 32'h40);
            brk <= 1'b1;
            repeat (100) @(posedge pclk);
            chk("sysrst", m, {31'h0, sys_reset_req});
            brk <= 1'b0;
            repeat (20) @(posedge pclk);
        end
        apb(1'b1, `ASP_CTRL_OFS, 32'h60);
        repeat (3) @(posedge pclk);
        chk("tx_brk", 32'h0, {31'h0, uart_tx});
        apb(1'b1, `ASP_CTRL_OFS, 32'h40);
        repeat (20 * BT) @(posedge pclk);
        presetn <= 1'b0;
        brk <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `ASP_BRKTH_OFS, 32'd50);
        apb(1'b1, `ASP_CTRL_OFS, 32'h50);
        repeat (100) @(posedge pclk);
        chk("hold", 32'h1, {31'h0, boot_hold});
        chk("hold_rst", 32'h0, {31'h0, sys_reset_req});
        brk <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("hold_end", 32'h0, {31'h0, boot_hold});
        close_out;
    end
endmodule // async_serial_port_with_break_tb
`default_nettype wire
